// ### verilog/cdb_pkg.sv
// Package for the compare/decrement branch execution block.
// Assumes a single core clock and one instruction started per request.
package cdb_pkg;
    localparam logic [7:0] CDB_OP_CMP_IND = 8'hb6; // low bit selects R0/R1
    localparam logic [7:0] CDB_OP_CMP_IND_MASK = 8'hfe;
    localparam logic [7:0] CDB_OP_DEC_REG = 8'hd8; // low three bits select R0..R7
    localparam logic [7:0] CDB_OP_DEC_REG_MASK = 8'hf8;
    localparam logic [7:0] CDB_OP_DEC_MEM = 8'hd5;
    localparam logic [15:0] CDB_LEN_TWO = 16'h0002;
    localparam logic [15:0] CDB_LEN_THREE = 16'h0003;
    localparam logic [1:0] CDB_CYCLES = 2'h2;
    localparam logic [15:0] CDB_PC_RESET = 16'h0000;
    localparam logic [2:0] CDB_REG_SEL_POS = 3'h0;
    typedef enum logic [1:0] {
        CDB_IDLE = 2'b00,
        CDB_EXEC = 2'b01
    } cdb_state_t;
endpackage

// ### verilog/cdb_target.sv
// Branch target adder: next PC plus signed displacement.
// Assumes the caller passes the instruction address; i_len steps the PC past the instruction here.
`timescale 1ns/10ps
module cdb_target
    import cdb_pkg::*;
(
    input wire logic [15:0] i_pc,
    input wire logic [15:0] i_len,
    input wire logic [7:0] i_disp,
    output logic [15:0] o_seq,
    output logic [15:0] o_taken
);
    always_comb begin
        o_seq = i_pc + i_len;
        o_taken = o_seq + {{8{i_disp[7]}}, i_disp}; // Signed offset [RQ6]
    end
endmodule

// ### verilog/cdb_exec.sv
// Execution unit for compare-indirect and decrement branch instructions.
// Assumes decode supplies the three instruction bytes and operand values.
`timescale 1ns/10ps
// Contract
// (RQ1) Compare-indirect is three bytes, two cycles, PC+3 then branch if @Ri differs.
// (RQ2) Compare-indirect sets carry when @Ri is below the immediate, else clears it.
// (RQ3) Byte two is the immediate and byte three the displacement.
// (RQ4) Decrement-register is two bytes, two cycles, PC+2, Rn-1, branch if nonzero.
// (RQ5) Decrement-memory is three bytes, PC+3, decrement direct byte, branch if nonzero.
// (RQ6) The displacement is signed and added to the already advanced PC.
module cdb_exec
    import cdb_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_reset,
    input wire logic i_start,
    input wire logic [7:0] i_opcode,
    input wire logic [7:0] i_byte2,
    input wire logic [7:0] i_byte3,
    input wire logic [15:0] i_pc,
    input wire logic [7:0] i_operand,
    output logic o_busy,
    output logic o_done,
    output logic o_illegal,
    output logic [15:0] o_pc,
    output logic o_pc_we,
    output logic o_carry,
    output logic o_carry_we,
    output logic [2:0] o_reg_sel,
    output logic [7:0] o_wr_addr,
    output logic [7:0] o_wr_data,
    output logic o_reg_we,
    output logic o_mem_we
);
    cdb_state_t state_reg, state_next;
    logic busy_reg, busy_next;
    // Decoded flags, so execute never sees the raw opcode
    logic cmp_reg, cmp_next;
    logic dreg_reg, dreg_next;
    logic dmem_reg, dmem_next;
    logic [7:0] b2_reg, b2_next;
    logic [7:0] b3_reg, b3_next;
    logic [15:0] pcin_reg, pcin_next;
    logic done_reg, done_next;
    logic ill_reg, ill_next;
    logic [15:0] pc_reg, pc_next;
    logic pcwe_reg, pcwe_next;
    logic c_reg, c_next;
    logic cwe_reg, cwe_next;
    logic [2:0] sel_reg, sel_next;
    logic [7:0] wa_reg, wa_next;
    logic [7:0] wd_reg, wd_next;
    logic rwe_reg, rwe_next;
    logic mwe_reg, mwe_next;
    logic is_cmp, is_dreg, is_dmem;
    logic [15:0] len;
    logic [7:0] disp;
    logic [7:0] dec;
    logic [15:0] seq_pc, taken_pc;

    // Refuse package values the datapath cannot serve
    if (CDB_CYCLES != 2'h2) begin : g_cycles_check
        $error("execution sequencer retires in exactly two cycles");
    end
    if (CDB_LEN_TWO >= CDB_LEN_THREE) begin : g_len_check
        $error("two-byte length must be below three-byte length");
    end
    if ((CDB_OP_CMP_IND & ~CDB_OP_CMP_IND_MASK) != 8'h00) begin : g_cmp_check
        $error("compare opcode has bits inside its register field");
    end
    if ((CDB_OP_DEC_REG & ~CDB_OP_DEC_REG_MASK) != 8'h00) begin : g_dreg_check
        $error("decrement opcode has bits inside its register field");
    end
    if ((CDB_OP_DEC_MEM & CDB_OP_DEC_REG_MASK) == CDB_OP_DEC_REG) begin : g_dmem_check
        $error("memory decrement opcode overlaps register decrement");
    end
    if (CDB_REG_SEL_POS > 3'h5) begin : g_sel_check
        $error("register field does not fit in the opcode");
    end

    // Decode on the incoming byte, registered at take
    always_comb begin
        is_cmp = (i_opcode & CDB_OP_CMP_IND_MASK) == CDB_OP_CMP_IND;
        is_dreg = (i_opcode & CDB_OP_DEC_REG_MASK) == CDB_OP_DEC_REG;
        is_dmem = i_opcode == CDB_OP_DEC_MEM;
        len = dreg_reg ? CDB_LEN_TWO : CDB_LEN_THREE; // [RQ1] [RQ4] [RQ5]
        disp = dreg_reg ? b2_reg : b3_reg; // [RQ3]
        dec = i_operand - 8'h01;
    end

    cdb_target cdb_target_inst (
        .i_pc(pcin_reg),
        .i_len(len),
        .i_disp(disp),
        .o_seq(seq_pc),
        .o_taken(taken_pc)
    );

    always_comb begin
        state_next = state_reg;
        busy_next = busy_reg;
        cmp_next = cmp_reg;
        dreg_next = dreg_reg;
        dmem_next = dmem_reg;
        b2_next = b2_reg;
        b3_next = b3_reg;
        pcin_next = pcin_reg;
        done_next = 1'b0;
        ill_next = 1'b0;
        pc_next = pc_reg;
        pcwe_next = 1'b0;
        c_next = c_reg;
        cwe_next = 1'b0;
        sel_next = sel_reg;
        wa_next = wa_reg;
        wd_next = wd_reg;
        rwe_next = 1'b0;
        mwe_next = 1'b0;
        unique case (state_reg)
            CDB_IDLE: begin
                if (i_start) begin
                    busy_next = 1'b1;
                    cmp_next = is_cmp;
                    dreg_next = is_dreg;
                    dmem_next = is_dmem;
                    b2_next = i_byte2;
                    b3_next = i_byte3;
                    pcin_next = i_pc;
                    // Operand select is issued in cycle one so it returns in cycle two
                    if (is_cmp) begin
                        sel_next = {2'h0, i_opcode[CDB_REG_SEL_POS]};
                    end else begin
                        sel_next = i_opcode[CDB_REG_SEL_POS +: 3]; // [RQ4]
                    end
                    wa_next = i_byte2;
                    state_next = CDB_EXEC;
                end
            end
            CDB_EXEC: begin
                // Second machine cycle: retire in two cycles total
                state_next = CDB_IDLE;
                busy_next = 1'b0;
                done_next = 1'b1;
                if (cmp_reg) begin
                    pcwe_next = 1'b1;
                    pc_next = (i_operand != b2_reg) ? taken_pc : seq_pc; // [RQ1] [RQ3]
                    cwe_next = 1'b1;
                    c_next = i_operand < b2_reg; // Unsigned compare [RQ2]
                end else if (dreg_reg || dmem_reg) begin
                    pcwe_next = 1'b1;
                    pc_next = (dec != 8'h00) ? taken_pc : seq_pc; // [RQ4] [RQ5] [RQ6]
                    wd_next = dec;
                    rwe_next = dreg_reg; // [RQ4]
                    mwe_next = dmem_reg; // [RQ5]
                end else begin
                    // Foreign opcodes leave PC and flags alone
                    ill_next = 1'b1;
                end
            end
            default: begin
                state_next = CDB_IDLE;
                busy_next = 1'b0;
            end
        endcase
    end

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            state_reg <= CDB_IDLE;
            busy_reg <= 1'b0;
            cmp_reg <= 1'b0;
            dreg_reg <= 1'b0;
            dmem_reg <= 1'b0;
            b2_reg <= 8'h00;
            b3_reg <= 8'h00;
            pcin_reg <= CDB_PC_RESET;
            done_reg <= 1'b0;
            ill_reg <= 1'b0;
            pc_reg <= CDB_PC_RESET;
            pcwe_reg <= 1'b0;
            c_reg <= 1'b0;
            cwe_reg <= 1'b0;
            sel_reg <= 3'h0;
            wa_reg <= 8'h00;
            wd_reg <= 8'h00;
            rwe_reg <= 1'b0;
            mwe_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            busy_reg <= busy_next;
            cmp_reg <= cmp_next;
            dreg_reg <= dreg_next;
            dmem_reg <= dmem_next;
            b2_reg <= b2_next;
            b3_reg <= b3_next;
            pcin_reg <= pcin_next;
            done_reg <= done_next;
            ill_reg <= ill_next;
            pc_reg <= pc_next;
            pcwe_reg <= pcwe_next;
            c_reg <= c_next;
            cwe_reg <= cwe_next;
            sel_reg <= sel_next;
            wa_reg <= wa_next;
            wd_reg <= wd_next;
            rwe_reg <= rwe_next;
            mwe_reg <= mwe_next;
        end
    end

    always_comb begin
        o_busy = busy_reg;
        o_done = done_reg;
        o_illegal = ill_reg;
        o_pc = pc_reg;
        o_pc_we = pcwe_reg;
        o_carry = c_reg;
        o_carry_we = cwe_reg;
        o_reg_sel = sel_reg;
        o_wr_addr = wa_reg;
        o_wr_data = wd_reg;
        o_reg_we = rwe_reg;
        o_mem_we = mwe_reg;
    end
endmodule

// ### test/cdb_exec_checker.sv
// Checker for the branch execution unit.
// Assumes binding to cdb_exec; sees only its ports.
`timescale 1ns/10ps
module cdb_exec_checker
    import cdb_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_reset,
    input wire logic i_start,
    input wire logic [7:0] i_opcode,
    input wire logic [7:0] i_byte2,
    input wire logic [7:0] i_byte3,
    input wire logic [15:0] i_pc,
    input wire logic [7:0] i_operand,
    input wire logic o_busy,
    input wire logic o_done,
    input wire logic o_illegal,
    input wire logic [15:0] o_pc,
    input wire logic o_pc_we,
    input wire logic o_carry,
    input wire logic o_carry_we,
    input wire logic [2:0] o_reg_sel,
    input wire logic [7:0] o_wr_addr,
    input wire logic [7:0] o_wr_data,
    input wire logic o_reg_we,
    input wire logic o_mem_we
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_reset);
    sequence s_take; i_start && !o_busy; endsequence
    sequence s_cmp; s_take ##0 (i_opcode & CDB_OP_CMP_IND_MASK) == CDB_OP_CMP_IND; endsequence
    sequence s_dreg; s_take ##0 (i_opcode & CDB_OP_DEC_REG_MASK) == CDB_OP_DEC_REG; endsequence
    sequence s_dmem; s_take ##0 i_opcode == CDB_OP_DEC_MEM; endsequence
    sequence s_retire; ##1 o_busy ##1 (o_done && !o_busy); endsequence
    property p_two_cycle; s_take |-> s_retire; endproperty
    a_two_cycle: assert property (p_two_cycle) else $error("retire late");
    property p_cmp_carry;
        s_cmp |-> ##2 o_carry_we && o_carry == ($past(i_operand) < $past(i_byte2, 2));
    endproperty
    a_cmp_carry: assert property (p_cmp_carry) else $error("bad carry");
    // Sign extension spelled out so a zero-extend slip fails here
    property p_cmp_pc;
        s_cmp |-> ##2 o_pc_we && !o_reg_we && !o_mem_we && o_pc == $past(i_pc, 2) + 16'h0003 +
            (($past(i_operand) != $past(i_byte2, 2)) ?
            {{8{$past(i_byte3[7], 2)}}, $past(i_byte3, 2)} : 16'h0000);
    endproperty
    a_cmp_pc: assert property (p_cmp_pc) else $error("bad compare pc");
    property p_dreg;
        s_dreg |-> ##2 o_reg_we && !o_mem_we && !o_carry_we && o_pc_we &&
            o_wr_data == $past(i_operand) - 8'h01 &&
            o_pc == $past(i_pc, 2) + 16'h0002 + (($past(i_operand) != 8'h01) ?
            {{8{$past(i_byte2[7], 2)}}, $past(i_byte2, 2)} : 16'h0000);
    endproperty
    a_dreg: assert property (p_dreg) else $error("bad reg decrement");
    property p_dmem;
        s_dmem |-> ##2 o_mem_we && !o_reg_we && !o_carry_we && o_pc_we &&
            o_wr_addr == $past(i_byte2, 2) && o_wr_data == $past(i_operand) - 8'h01 &&
            o_pc == $past(i_pc, 2) + 16'h0003 + (($past(i_operand) != 8'h01) ?
            {{8{$past(i_byte3[7], 2)}}, $past(i_byte3, 2)} : 16'h0000);
    endproperty
    a_dmem: assert property (p_dmem) else $error("bad mem decrement");
    property p_ill;
        o_illegal |-> o_done && !o_pc_we && !o_carry_we && !o_reg_we && !o_mem_we;
    endproperty
    a_ill: assert property (p_ill) else $error("illegal with effects");
    property p_busy_one; o_busy |=> !o_busy; endproperty
    a_busy_one: assert property (p_busy_one) else $error("busy too long");
    property p_strobe; (o_pc_we || o_reg_we || o_mem_we || o_carry_we) |-> o_done; endproperty
    a_strobe: assert property (p_strobe) else $error("stray strobe");
    property p_cmp_sel; s_cmp |=> o_reg_sel == {2'h0, $past(i_opcode[0])}; endproperty
    a_cmp_sel: assert property (p_cmp_sel) else $error("bad compare select");
    property p_dreg_sel; s_dreg |=> o_reg_sel == $past(i_opcode[2:0]); endproperty
    a_dreg_sel: assert property (p_dreg_sel) else $error("bad register select");
endmodule

bind cdb_exec cdb_exec_checker cdb_exec_checker_inst (.*);

// ### test/compare_decrement_branch_exec_tb.sv
// Self-checking bench for the branch execution unit.
// Assumes cdb_exec with its operand supplied one cycle after start.
`timescale 1ns/10ps
module compare_decrement_branch_exec_tb
    import cdb_pkg::*;
;
    logic i_clk = 1'b0, i_reset = 1'b1, i_start = 1'b0;
    logic [7:0] i_opcode = 8'h00, i_byte2 = 8'h00, i_byte3 = 8'h00, i_operand = 8'h00;
    logic [15:0] i_pc = 16'h0000, o_pc;
    logic o_busy, o_done, o_illegal, o_pc_we, o_carry, o_carry_we, o_reg_we, o_mem_we;
    logic [2:0] o_reg_sel;
    logic [7:0] o_wr_addr, o_wr_data;
    int err_total = 0, checks_done = 0;
    always #5 i_clk = ~i_clk;
    cdb_exec cdb_exec_inst (
        .i_clk(i_clk),
        .i_reset(i_reset),
        .i_start(i_start),
        .i_opcode(i_opcode),
        .i_byte2(i_byte2),
        .i_byte3(i_byte3),
        .i_pc(i_pc),
        .i_operand(i_operand),
        .o_busy(o_busy),
        .o_done(o_done),
        .o_illegal(o_illegal),
        .o_pc(o_pc),
        .o_pc_we(o_pc_we),
        .o_carry(o_carry),
        .o_carry_we(o_carry_we),
        .o_reg_sel(o_reg_sel),
        .o_wr_addr(o_wr_addr),
        .o_wr_data(o_wr_data),
        .o_reg_we(o_reg_we),
        .o_mem_we(o_mem_we)
    );
    task automatic tally_and_finish;
        if (err_total == 0 && checks_done > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        checks_done++;
        if (s !== e) begin
            err_total++;
            $display("unexpected t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask
    task automatic go(input logic [7:0] op, b2, b3, opd, input logic [15:0] pc);
        int n = 0;
        @(posedge i_clk);
        #1 i_start = 1'b1;
        {i_opcode, i_byte2, i_byte3, i_pc} = {op, b2, b3, pc};
        @(posedge i_clk);
        #1 i_start = 1'b0;
        i_operand = opd;
        while (o_done !== 1'b1 && n < 4) begin
            @(posedge i_clk);
            #1 n++;
        end
        if (o_done !== 1'b1) begin
            err_total++;
            tally_and_finish;
        end
    endtask
    task automatic t_cmp;
        for (int r = 0; r < 2; r++) begin
            go(8'hb6 | 8'(r), 8'h40, 8'hf0, 8'h3f, 16'h1000);
            chk({o_carry, o_pc}, 17'h10ff3);
            chk({o_pc_we, o_carry_we, o_reg_we, o_mem_we, o_illegal}, 32'h18);
            chk(o_reg_sel, 16'(r));
            go(8'hb6 | 8'(r), 8'h40, 8'h10, 8'h40, 16'h2000);
            chk({o_carry, o_pc}, 17'h02003);
        end
        go(8'hb7, 8'h40, 8'h10, 8'h41, 16'hfff0);
        chk({o_carry, o_pc}, 17'h00003);
    endtask
    task automatic t_dreg;
        // Byte three is junk on purpose: the two-byte form ignores it
        for (int r = 0; r < 8; r++) begin
            go(8'hd8 + 8'(r), 8'h05, 8'hff, 8'(r), 16'h0300);
            chk({o_reg_we, o_wr_data}, {8'h01, 8'(r - 1)});
            chk({o_pc_we, o_carry_we, o_mem_we, o_illegal}, 32'h8);
            chk(o_reg_sel, 16'(r));
            chk(o_pc, (r == 1) ? 16'h0302 : 16'h0307);
        end
    endtask
    task automatic t_dmem;
        go(8'hd5, 8'h7e, 8'h80, 8'h01, 16'hfff0);
        chk({o_mem_we, o_wr_addr, o_wr_data}, 17'h17e00);
        chk(o_pc, 16'hfff3);
        chk({o_pc_we, o_carry_we, o_reg_we, o_illegal}, 32'h8);
        go(8'hd5, 8'h31, 8'h80, 8'h02, 16'hfff0);
        chk({o_mem_we, o_wr_addr, o_wr_data}, 17'h13101);
        chk(o_pc, 16'hff73);
    endtask
    task automatic t_ill;
        go(8'h00, 8'h00, 8'h00, 8'h00, 16'h0100);
        chk({o_illegal, o_pc_we, o_carry_we, o_reg_we, o_mem_we}, 16'h0010);
        chk({o_busy, o_done}, 32'h1);
    endtask
    task automatic t_busy;
        // A start during the execute cycle must be ignored
        @(posedge i_clk);
        #1 i_start = 1'b1;
        {i_opcode, i_byte2, i_byte3, i_pc} = {8'hb6, 8'h40, 8'h10, 16'h4000};
        @(posedge i_clk);
        #1 i_opcode = 8'hd5;
        i_operand = 8'h40;
        @(posedge i_clk);
        #1 i_start = 1'b0;
        chk({o_done, o_mem_we, o_pc}, 32'h24003);
        @(posedge i_clk);
        #1 chk({o_done, o_busy, o_mem_we}, 32'h0);
    endtask
    initial begin
        repeat (5) @(posedge i_clk);
        #1 i_reset = 1'b0;
        t_cmp();
        t_dreg();
        t_dmem();
        t_ill();
        t_busy();
        tally_and_finish;
    end
endmodule
